// File: src/wss_pkg.sv
// constants, register map and state encoding of the waveform slot sequencer
// assumes a 125 MHz bus clock and word-aligned single AHB-Lite transfers
//
// Contract
// [R1] each slot register holds a delay flag in bit 7 and a seven-bit value in bits 6..0, both resetting to zero.
// [R2] a slot with its delay flag set idles the playback engine for value times 10 ms.
// [R3] a slot with its delay flag clear names a waveform to be played in the sequence.
// [R4] a waveform identifier is used as the index of the waveform in the stored library.
// [R5] software starts playback by setting the trigger bit at index 0x0c, and playback begins at the slot at index 0x0f.
// [R6] when a slot's waveform ends the sequencer moves to the next slot and plays it if its value is not zero.
// [R7] the sequencer stops at a zero-valued slot or after the eighth slot (0x0f..0x16), whichever comes first.
package wss_pkg;

    // ------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_TRIGGER    = 6'h0c;
    localparam logic [5:0] IDX_SLOT_FIRST = 6'h0f;
    localparam logic [5:0] IDX_SLOT_THREE = 6'h11;
    localparam logic [5:0] IDX_SLOT_FOUR  = 6'h12;
    localparam logic [5:0] IDX_SLOT_LAST  = 6'h16;
    localparam int         NUM_SLOTS      = 8;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int         TRIG_GO_BIT    = 0;
    localparam int         TRIG_CUR_LSB   = 1;
    localparam int         SLOT_DELAY_BIT = 7;
    localparam int         SLOT_VALUE_MSB = 6;
    localparam logic [7:0] SLOT_RESET     = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int DELAY_STEP_MS = 10;
    localparam int DELAY_STEP_CYCLES = DELAY_STEP_MS * 1000000 / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // sequencer states, gray in the order idle-fetch-play-wait
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WSS_IDLE  = 2'b00,
        WSS_FETCH = 2'b01,
        WSS_PLAY  = 2'b11,
        WSS_WAIT  = 2'b10
    } wss_state_t;

endpackage : wss_pkg

// File: src/wss_step_timer.sv
// idle-period timer: counts a number of 10 ms steps
// assumes units is non-zero when start is pulsed
`timescale 1ns/1ps
`default_nettype none
module wss_step_timer #(
    parameter int STEP_CYCLES = wss_pkg::DELAY_STEP_CYCLES
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic [6:0] units,
    output logic            done
);
    logic [23:0] step_q, step_d;
    logic [6:0]  unit_q, unit_d;
    logic        run_q,  run_d;
    logic        done_q, done_d;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        step_d = step_q;
        unit_d = unit_q;
        run_d  = run_q;
        done_d = 1'b0;
        if (abort) begin
            run_d = 1'b0;
        end else if (start) begin
            step_d = 24'h000000;
            unit_d = units;
            run_d  = 1'b1;
        end else if (run_q) begin
            if (step_q == 24'(STEP_CYCLES - 1)) begin
                step_d = 24'h000000;
                unit_d = unit_q - 7'h01;
                if (unit_q == 7'h01) begin
                    run_d  = 1'b0;
                    done_d = 1'b1;
                end
            end else begin
                step_d = step_q + 24'h000001;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_q <= 24'h000000;
            unit_q <= 7'h00;
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end else begin
            step_q <= step_d;
            unit_q <= unit_d;
            run_q  <= run_d;
            done_q <= done_d;
        end
    end

    assign done = done_q;

endmodule : wss_step_timer
`default_nettype wire

// File: src/wss_top.sv
// waveform slot sequencer: eight slot registers, trigger, AHB-Lite slave
// assumes play_done comes from the playback engine on hclk
`timescale 1ns/1ps
`default_nettype none
module wss_top #(
    parameter int STEP_CYCLES = wss_pkg::DELAY_STEP_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        play_done,
    output logic             play_start,
    output logic [6:0]       play_index,
    output logic             seq_busy
);
    localparam int NS = wss_pkg::NUM_SLOTS;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    // zero wait states: read data is fetched in the address phase so it
    // stands from a flop during the data phase
    logic        addr_ph;
    logic        wr_q, wr_d;
    logic [5:0]  idx_q, idx_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0]  slot_q [NS];
    logic [7:0]  slot_d [NS];
    logic        go_q, go_d;
    logic [2:0]  cur_q, cur_d;
    wss_pkg::wss_state_t st_q, st_d;
    logic        start_q, start_d;
    logic [6:0]  pidx_q, pidx_d;
    logic        go_wr, go_wval;
    logic [5:0]  a_idx;
    logic [5:0]  a_off, w_off;
    logic [7:0]  cur_slot;
    logic        tmr_start, tmr_abort, tmr_done;

    assign addr_ph = hsel & htrans[1] & hready;
    assign a_idx   = haddr[7:2];
    assign a_off   = a_idx - wss_pkg::IDX_SLOT_FIRST;
    assign w_off   = idx_q - wss_pkg::IDX_SLOT_FIRST;
    assign go_wr   = wr_q && (idx_q == wss_pkg::IDX_TRIGGER);
    assign go_wval = hwdata[wss_pkg::TRIG_GO_BIT];

    always_comb begin
        wr_d    = addr_ph & hwrite;
        idx_d   = addr_ph ? a_idx : idx_q;
        rdata_d = 32'h00000000;
        if (addr_ph && !hwrite) begin
            if (a_idx == wss_pkg::IDX_TRIGGER) begin
                rdata_d[wss_pkg::TRIG_GO_BIT] = go_d;
                rdata_d[wss_pkg::TRIG_CUR_LSB +: 3] = cur_d;
            end else if (a_idx >= wss_pkg::IDX_SLOT_FIRST &&
                         a_idx <= wss_pkg::IDX_SLOT_LAST) begin
                rdata_d[7:0] = slot_d[a_off[2:0]]; // [R1]
            end
        end
    end

    // slot writes land in the data phase; the read path looks at the
    // next value so a read right behind a write sees the new data
    always_comb begin
        for (int i = 0; i < NS; i++) begin
            slot_d[i] = slot_q[i];
        end
        if (wr_q && idx_q >= wss_pkg::IDX_SLOT_FIRST &&
            idx_q <= wss_pkg::IDX_SLOT_LAST) begin
            slot_d[w_off[2:0]] = hwdata[7:0]; // [R1]
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    assign cur_slot = slot_q[cur_q];

    always_comb begin
        st_d      = st_q;
        cur_d     = cur_q;
        go_d      = go_q;
        start_d   = 1'b0;
        pidx_d    = pidx_q;
        tmr_start = 1'b0;
        tmr_abort = 1'b0;
        unique case (st_q)
            wss_pkg::WSS_IDLE: begin
                if (go_wr && go_wval) begin
                    go_d  = 1'b1;
                    cur_d = 3'h0; // [R5]
                    st_d  = wss_pkg::WSS_FETCH;
                end
            end
            wss_pkg::WSS_FETCH: begin
                if (cur_slot[wss_pkg::SLOT_VALUE_MSB:0] == 7'h00) begin
                    go_d = 1'b0; // [R7]
                    st_d = wss_pkg::WSS_IDLE;
                end else if (cur_slot[wss_pkg::SLOT_DELAY_BIT]) begin
                    tmr_start = 1'b1; // [R2]
                    st_d      = wss_pkg::WSS_WAIT;
                end else begin
                    start_d = 1'b1; // [R3]
                    pidx_d  = cur_slot[wss_pkg::SLOT_VALUE_MSB:0]; // [R4]
                    st_d    = wss_pkg::WSS_PLAY;
                end
            end
            wss_pkg::WSS_PLAY, wss_pkg::WSS_WAIT: begin
                if ((st_q == wss_pkg::WSS_PLAY && play_done) ||
                    (st_q == wss_pkg::WSS_WAIT && tmr_done)) begin
                    if (cur_q == 3'(NS - 1)) begin
                        go_d = 1'b0; // [R7]
                        st_d = wss_pkg::WSS_IDLE;
                    end else begin
                        cur_d = cur_q + 3'h1; // [R6]
                        st_d  = wss_pkg::WSS_FETCH;
                    end
                end
            end
        endcase
        // writing zero to the trigger aborts; the abort wins over a pending start
        if (go_wr && !go_wval && st_q != wss_pkg::WSS_IDLE) begin
            go_d      = 1'b0;
            start_d   = 1'b0;
            tmr_abort = 1'b1;
            st_d      = wss_pkg::WSS_IDLE;
        end
    end

    wss_step_timer #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (tmr_start),
        .abort   (tmr_abort),
        .units   (cur_slot[wss_pkg::SLOT_VALUE_MSB:0]),
        .done    (tmr_done)
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q    <= 1'b0;
            idx_q   <= 6'h00;
            rdata_q <= 32'h00000000;
            for (int i = 0; i < NS; i++) begin
                slot_q[i] <= wss_pkg::SLOT_RESET; // [R1]
            end
            go_q    <= 1'b0;
            cur_q   <= 3'h0;
            st_q    <= wss_pkg::WSS_IDLE;
            start_q <= 1'b0;
            pidx_q  <= 7'h00;
        end else begin
            wr_q    <= wr_d;
            idx_q   <= idx_d;
            rdata_q <= rdata_d;
            for (int i = 0; i < NS; i++) begin
                slot_q[i] <= slot_d[i];
            end
            go_q    <= go_d;
            cur_q   <= cur_d;
            st_q    <= st_d;
            start_q <= start_d;
            pidx_q  <= pidx_d;
        end
    end

    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = rdata_q;
    assign play_start = start_q;
    assign play_index = pidx_q;
    assign seq_busy   = go_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_slot_read_high_zero;
        @(posedge hclk) disable iff (!hresetn)
        (addr_ph && !hwrite && a_idx == wss_pkg::IDX_SLOT_THREE)
            |=> (hrdata[31:8] == 24'h000000 && hrdata[7:0] == slot_q[2]);
    endproperty
    a_slot_read_high_zero: assert property (p_slot_read_high_zero) // [R1]
        else $error("slot read data wrong");

    property p_delay_enters_wait;
        @(posedge hclk) disable iff (!hresetn)
        (st_q == wss_pkg::WSS_FETCH && cur_slot[7] && cur_slot[6:0] != 7'h00
         && !go_wr) |=> (st_q == wss_pkg::WSS_WAIT && !play_start);
    endproperty
    a_delay_enters_wait: assert property (p_delay_enters_wait) // [R2]
        else $error("delay slot did not idle");

    property p_wave_starts_play;
        @(posedge hclk) disable iff (!hresetn)
        (st_q == wss_pkg::WSS_FETCH && !cur_slot[7] && cur_slot[6:0] != 7'h00
         && !go_wr) |=> (play_start && st_q == wss_pkg::WSS_PLAY);
    endproperty
    a_wave_starts_play: assert property (p_wave_starts_play) // [R3]
        else $error("waveform slot did not play");

    property p_index_from_slot;
        @(posedge hclk) disable iff (!hresetn)
        play_start |-> (play_index == slot_q[cur_q][6:0]);
    endproperty
    a_index_from_slot: assert property (p_index_from_slot) // [R4]
        else $error("play index differs from slot value");

    property p_go_starts_first;
        @(posedge hclk) disable iff (!hresetn)
        (st_q == wss_pkg::WSS_IDLE && go_wr && go_wval)
            |=> (st_q == wss_pkg::WSS_FETCH && cur_q == 3'h0 && seq_busy);
    endproperty
    a_go_starts_first: assert property (p_go_starts_first) // [R5]
        else $error("trigger did not start at first slot");

    property p_advance;
        @(posedge hclk) disable iff (!hresetn)
        (st_q == wss_pkg::WSS_PLAY && play_done && cur_q != 3'h7 && !go_wr)
            |=> (st_q == wss_pkg::WSS_FETCH && cur_q == $past(cur_q) + 3'h1);
    endproperty
    a_advance: assert property (p_advance) // [R6]
        else $error("sequencer did not advance");

    property p_stop;
        @(posedge hclk) disable iff (!hresetn)
        ((st_q == wss_pkg::WSS_FETCH && cur_slot[6:0] == 7'h00) ||
         (st_q == wss_pkg::WSS_PLAY && play_done && cur_q == 3'h7))
            |=> (st_q == wss_pkg::WSS_IDLE && !seq_busy);
    endproperty
    a_stop: assert property (p_stop) // [R7]
        else $error("sequencer did not stop");

endmodule : wss_top
`default_nettype wire

// File: tb/wss_engine_model.sv
// playback engine model: ends each started waveform after a set time
// assumes play_start is a one-cycle pulse on hclk and latency is not zero
`timescale 1ns/1ps
`default_nettype none
module wss_engine_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       play_start,
    input  wire logic [7:0] latency,
    output logic            play_done
);
    // ------------------------------------------------------------
    // waveform length counter
    // ------------------------------------------------------------
    int unsigned left;

    // latency is read at start, so the bench can switch prompt/slow
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            left      <= 0;
            play_done <= 1'b0;
        end else begin
            play_done <= (left == 1);
            if (play_start) begin
                left <= latency;
            end else if (left != 0) begin
                left <= left - 1;
            end
        end
    end
endmodule : wss_engine_model
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the waveform slot sequencer
// assumes STEP_CYCLES shortened to 4 and the engine model on play_done
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    localparam int STEP = 4;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0]  latency = 8'h03;
    logic        hready, hresp, play_done, play_start, seq_busy;
    logic [31:0] hrdata;
    logic [6:0]  play_index;
    int          fail_count = 0;
    int          checks_done = 0;
    int          cyc = 0;
    logic [6:0]  plays[$];
    int          starts[$];
    int          dones[$];

    wss_top #(.STEP_CYCLES(STEP)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .play_done(play_done), .play_start(play_start),
        .play_index(play_index), .seq_busy(seq_busy));
    wss_engine_model u_engine (
        .hclk(hclk), .hresetn(hresetn), .play_start(play_start),
        .latency(latency), .play_done(play_done));

    always #4 hclk = ~hclk;

    // pulses stand one cycle, so the falling edge sees each once
    always @(negedge hclk) begin
        if (play_start === 1'b1) begin
            plays.push_back(play_index);
            starts.push_back(cyc);
        end
        if (play_done === 1'b1) begin
            dones.push_back(cyc);
        end
    end

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // entered just after a rising edge; returns just after one
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(negedge hclk);
            rd = hrdata;
            @(posedge hclk);
        end while (hready !== 1'b1);
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, a, d, unused);
    endtask : wr

    task automatic rd_chk(input string what, input logic [31:0] a,
                          input logic [31:0] exp);
        logic [31:0] got;
        bus(1'b0, a, 32'h0, got);
        chk(what, exp, got);
    endtask : rd_chk

    function automatic logic [31:0] slot_addr(input int k);
        return 32'((wss_pkg::IDX_SLOT_FIRST + k) * 4);
    endfunction : slot_addr

    task automatic go_and_wait();
        int n;
        plays.delete();
        starts.delete();
        dones.delete();
        wr(32'(wss_pkg::IDX_TRIGGER * 4), 32'h1);
        @(posedge hclk);
        @(negedge hclk);
        chk("busy after trigger", 32'h1, {31'h0, seq_busy});
        n = 0;
        while (seq_busy !== 1'b0 && n < 3000) begin
            @(negedge hclk);
            n++;
        end
        chk("sequence ended", 32'h0, {31'h0, seq_busy});
        @(posedge hclk);
    endtask : go_and_wait

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_regs();
        rd_chk("slot three reset", slot_addr(2), 32'h0);
        rd_chk("slot four reset", slot_addr(3), 32'h0);
        wr(slot_addr(2), 32'h85);
        rd_chk("slot three rw", slot_addr(2), 32'h85);
        wr(slot_addr(3), 32'hffffff7a);
        rd_chk("slot four rw", slot_addr(3), 32'h7a);
        rd_chk("unmapped", 32'hfc, 32'h0);
    endtask : s_regs

    // waveform, 2-step idle, waveform, zero entry stops the rest
    task automatic s_seq();
        logic [7:0] v[8] = '{8'h05, 8'h82, 8'h11, 8'h00,
                             8'h33, 8'h33, 8'h33, 8'h33};
        int gap;
        latency <= 8'h03;
        for (int k = 0; k < 8; k++) begin
            wr(slot_addr(k), {24'h0, v[k]});
        end
        go_and_wait();
        chk("plays", 32'h2, 32'(plays.size()));
        chk("first index", 32'h05, {25'h0, plays[0]});
        chk("next index", 32'h11, {25'h0, plays[1]});
        gap = starts[1] - dones[0];
        chk("idle gap", 32'h1, {31'h0, gap >= 2 * STEP && gap <= 2 * STEP + 6});
    endtask : s_seq

    // all eight waveforms, slow engine, stops after the eighth
    task automatic s_full();
        latency <= 8'h28;
        for (int k = 0; k < 8; k++) begin
            wr(slot_addr(k), 32'(k * 15 + 7));
        end
        go_and_wait();
        chk("plays", 32'h8, 32'(plays.size()));
        for (int k = 0; k < 8; k++) begin
            chk("index", 32'(k * 15 + 7), {25'h0, plays[k]});
        end
    endtask : s_full

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        s_regs();
        s_seq();
        s_full();
        complete_run();
    end
endmodule : testbench
`default_nettype wire
